// ---- pspwm_gate_map.svh ----
// Timing constants and rule summary of the phase-shifted gate generator
//
// Summary of operation
// - Three gate signals plus three complements only
// - Polarity at 60 Hz, cells near 20 kHz
// - Polarity high positive half, low negative
// - Cells from modulation versus carrier compare
// - Two carriers 180 degrees apart
// - Three bits encode eight states, five levels
// - State 1 gives full positive bus
// - States 2/3 and 6/7 are redundant pairs
// - Alternate redundant states to balance capacitors
// - State 2 half positive, charges caps
// - State 3 half positive, discharges caps
// - State 4 zero volts, caps bypassed
// - State 5 zero volts, caps bypassed
// - State 6 half negative, discharges caps
// - State 7 half negative, charges caps
// - State 8 full negative, caps bypassed
// - One output drives a series switch pair
`ifndef PSPWM_GATE_MAP_SVH
`define PSPWM_GATE_MAP_SVH

// ----------------------------------------
// Clock and frequencies
// ----------------------------------------
`define CLK_FREQ_HZ     100000000
`define CARRIER_FREQ_HZ 20000
`define LINE_FREQ_HZ    60

// ----------------------------------------
// Derived cycle counts (rounded down)
// ----------------------------------------
`define CARRIER_PEAK    (`CLK_FREQ_HZ / (2 * `CARRIER_FREQ_HZ))
`define LINE_HALF_CYC   (`CLK_FREQ_HZ / (2 * `LINE_FREQ_HZ))

// ----------------------------------------
// Field widths and reset values
// ----------------------------------------
`define CARRIER_W       12
`define LINE_W          20
`define DEAD_W          8
`define GATE_CH         3
`define MOD_RST         12'h000
`define POL_RST         1'b1

`endif

// ---- pspwm_gate_pkg.sv ----
// Types shared by the phase-shifted gate generator
package pspwm_gate_pkg;

	// Run control, one-hot
	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_RUN  = 2'b10
	} run_state_t;

	// Bridge output level in quarter-free units: -2..+2 times half bus
	typedef logic signed [2:0] bridge_level_t;

endpackage

// ---- pspwm_gate_gen.sv ----
// Five-level phase-shifted PWM gate generator with dead time
`timescale 1ns/1ns
`include "pspwm_gate_map.svh"

module pspwm_gate_gen #(
	parameter int LINE_HALF = `LINE_HALF_CYC
) (
	// Clock and reset
	input  wire logic                     mclk,
	input  wire logic                     arst_n,
	// Run request from a pin
	input  wire logic                     gate_enable,
	// Modulation and dead time from local logic
	input  wire logic [`CARRIER_W-1:0]    modulation_value,
	input  wire logic [`DEAD_W-1:0]       dead_time,
	// Gate drive outputs
	output logic                          polarity_select,
	output logic                          polarity_select_n,
	output logic                          cell_a_pwm,
	output logic                          cell_a_pwm_n,
	output logic                          cell_b_pwm,
	output logic                          cell_b_pwm_n,
	// Status
	output logic [3:0]                    switching_state,
	output logic signed [2:0]             bridge_output_voltage,
	output logic                          running
);

	// ----------------------------------------
	// Constants at working width
	// ----------------------------------------
	localparam logic [`CARRIER_W-1:0] PEAK      = `CARRIER_W'(`CARRIER_PEAK);
	localparam logic [`LINE_W-1:0]    LINE_LAST = `LINE_W'(LINE_HALF - 1);
	localparam logic [`DEAD_W-1:0]    DEAD_MAX  = {`DEAD_W{1'b1}};

	// ----------------------------------------
	// Enable synchroniser
	// ----------------------------------------
	logic en_meta_ff;
	logic en_sync_ff;

	// Pin enable passes two flops before use
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			en_meta_ff <= 1'b0;
			en_sync_ff <= 1'b0;
		end else begin
			en_meta_ff <= gate_enable;
			en_sync_ff <= en_meta_ff;
		end
	end

	// ----------------------------------------
	// Run state machine
	// ----------------------------------------
	pspwm_gate_pkg::run_state_t state_ff;
	pspwm_gate_pkg::run_state_t nxt_state;
	logic                       nxt_running;
	logic                       running_ff;
	logic                       valley;

	// Start and stop only at a carrier valley, which cuts the pulse centred there short (cell A in the positive half, cell B in the negative)
	always_comb begin
		nxt_state = state_ff;
		unique case (state_ff)
			pspwm_gate_pkg::ST_IDLE: begin
				if (en_sync_ff) begin
					nxt_state = pspwm_gate_pkg::ST_RUN;
				end
			end
			pspwm_gate_pkg::ST_RUN: begin
				if (!en_sync_ff && valley) begin
					nxt_state = pspwm_gate_pkg::ST_IDLE;
				end
			end
			default: begin
				nxt_state = pspwm_gate_pkg::ST_IDLE;
			end
		endcase
		nxt_running = (nxt_state == pspwm_gate_pkg::ST_RUN);
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			state_ff   <= pspwm_gate_pkg::ST_IDLE;
			running_ff <= 1'b0;
		end else begin
			state_ff   <= nxt_state;
			running_ff <= nxt_running;
		end
	end

	// ----------------------------------------
	// Triangle carriers
	// ----------------------------------------
	logic [`CARRIER_W-1:0] car_a_ff;
	logic [`CARRIER_W-1:0] nxt_car_a;
	logic                  car_up_ff;
	logic                  nxt_car_up;
	logic [`CARRIER_W-1:0] car_b;
	logic                  is_run;

	assign is_run = (state_ff == pspwm_gate_pkg::ST_RUN);
	// Direction turns at one, so zero shows once per period, already counting up
	assign valley = (car_a_ff == '0);

	// symmetric up-down counter
	// Carrier held at its valley while idle so a start is clean
	always_comb begin
		nxt_car_a  = car_a_ff;
		nxt_car_up = car_up_ff;
		if (!is_run) begin
			nxt_car_a  = '0;
			nxt_car_up = 1'b1;
		end else if (car_up_ff) begin
			if (car_a_ff == PEAK - 1'b1) begin
				nxt_car_up = 1'b0;
			end
			nxt_car_a = car_a_ff + 1'b1;
		end else begin
			if (car_a_ff == `CARRIER_W'(1)) begin
				nxt_car_up = 1'b1;
			end
			nxt_car_a = car_a_ff - 1'b1;
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			car_a_ff  <= '0;
			car_up_ff <= 1'b1;
		end else begin
			car_a_ff  <= nxt_car_a;
			car_up_ff <= nxt_car_up;
		end
	end

	// second carrier half a period later
	// Mirror of a symmetric triangle equals a half-period shift
	assign car_b = PEAK - car_a_ff;

	// ----------------------------------------
	// Modulation sampling
	// ----------------------------------------
	logic [`CARRIER_W-1:0] mod_ff;
	logic [`CARRIER_W-1:0] nxt_mod;

	// Sampled once per carrier valley while running and every cycle while idle; clamped to the carrier peak
	always_comb begin
		nxt_mod = mod_ff;
		if (valley || !is_run) begin
			nxt_mod = (modulation_value > PEAK) ? PEAK : modulation_value;
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			mod_ff <= `MOD_RST;
		end else begin
			mod_ff <= nxt_mod;
		end
	end

	// ----------------------------------------
	// Line polarity timer
	// ----------------------------------------
	logic [`LINE_W-1:0] line_cnt_ff;
	logic [`LINE_W-1:0] nxt_line_cnt;
	logic               pol_ff;
	logic               nxt_pol;

	// high for positive half, low for negative
	always_comb begin
		nxt_line_cnt = line_cnt_ff;
		nxt_pol      = pol_ff;
		if (!is_run) begin
			nxt_line_cnt = '0;
			nxt_pol      = `POL_RST;
		end else if (line_cnt_ff == LINE_LAST) begin
			nxt_line_cnt = '0;
			nxt_pol      = !pol_ff;
		end else begin
			nxt_line_cnt = line_cnt_ff + 1'b1;
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			line_cnt_ff <= '0;
			pol_ff      <= `POL_RST;
		end else begin
			line_cnt_ff <= nxt_line_cnt;
			pol_ff      <= nxt_pol;
		end
	end

	// ----------------------------------------
	// Cell demand and state decode
	// ----------------------------------------
	logic                          dem_a;
	logic                          dem_b;
	logic [`GATE_CH-1:0]           demand;
	logic [3:0]                    nxt_sw_state;
	logic signed [2:0]             nxt_level;
	logic [3:0]                    sw_state_ff;
	logic signed [2:0]             level_ff;

	// compare one modulation value with both carriers
	// In the negative half a high cell raises the level, so the sense flips
	assign dem_a = (mod_ff > car_a_ff) ^ !pol_ff;
	assign dem_b = (mod_ff > car_b) ^ !pol_ff;

	// each demand drives a whole series pair
	assign demand = {dem_b, dem_a, pol_ff};

	// three bits give eight states, five levels
	// phase shift alternates 2/3 and 6/7 each carrier half
	always_comb begin
		nxt_sw_state = 4'h0;
		nxt_level    = 3'sh0;
		if (is_run) begin
			unique case ({pol_ff, dem_a, dem_b})
				3'b111: begin
					nxt_sw_state = 4'h1;
					nxt_level    = 3'sh2;
				end
				3'b110: begin
					nxt_sw_state = 4'h2;
					nxt_level    = 3'sh1;
				end
				3'b101: begin
					nxt_sw_state = 4'h3;
					nxt_level    = 3'sh1;
				end
				3'b100: begin
					nxt_sw_state = 4'h4;
					nxt_level    = 3'sh0;
				end
				3'b011: begin
					nxt_sw_state = 4'h5;
					nxt_level    = 3'sh0;
				end
				3'b010: begin
					nxt_sw_state = 4'h6;
					nxt_level    = -3'sh1;
				end
				3'b001: begin
					nxt_sw_state = 4'h7;
					nxt_level    = -3'sh1;
				end
				3'b000: begin
					nxt_sw_state = 4'h8;
					nxt_level    = -3'sh2;
				end
			endcase
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			sw_state_ff <= 4'h0;
			level_ff    <= 3'sh0;
		end else begin
			sw_state_ff <= nxt_sw_state;
			level_ff    <= nxt_level;
		end
	end

	// ----------------------------------------
	// Dead time insertion per channel
	// ----------------------------------------
	logic [`GATE_CH-1:0] gate_hi_ff;
	logic [`GATE_CH-1:0] gate_lo_ff;

	genvar ch;
	generate
		for (ch = 0; ch < `GATE_CH; ch++) begin : g_dead
			logic               last_ff;
			logic               nxt_last;
			logic [`DEAD_W-1:0] dt_cnt_ff;
			logic [`DEAD_W-1:0] nxt_dt_cnt;
			logic               nxt_hi;
			logic               nxt_lo;

			// both sides off until dead time expires
			// Dead time is read live; a change acts from the next edge
			always_comb begin
				nxt_last   = demand[ch];
				nxt_dt_cnt = dt_cnt_ff;
				if (demand[ch] != last_ff) begin
					nxt_dt_cnt = '0;
				end else if (dt_cnt_ff != DEAD_MAX) begin
					nxt_dt_cnt = dt_cnt_ff + 1'b1;
				end
				nxt_hi = is_run && (demand[ch] == last_ff) && demand[ch]
				         && (dt_cnt_ff >= dead_time);
				nxt_lo = is_run && (demand[ch] == last_ff) && !demand[ch]
				         && (dt_cnt_ff >= dead_time);
			end

			always_ff @(posedge mclk or negedge arst_n) begin
				if (!arst_n) begin
					last_ff        <= 1'b0;
					dt_cnt_ff      <= '0;
					gate_hi_ff[ch] <= 1'b0;
					gate_lo_ff[ch] <= 1'b0;
				end else begin
					last_ff        <= nxt_last;
					dt_cnt_ff      <= nxt_dt_cnt;
					gate_hi_ff[ch] <= nxt_hi;
					gate_lo_ff[ch] <= nxt_lo;
				end
			end
		end
	endgenerate

	// ----------------------------------------
	// Output mapping
	// ----------------------------------------
	// All outputs come straight from flops
	assign polarity_select       = gate_hi_ff[0];
	assign polarity_select_n     = gate_lo_ff[0];
	assign cell_a_pwm            = gate_hi_ff[1];
	assign cell_a_pwm_n          = gate_lo_ff[1];
	assign cell_b_pwm            = gate_hi_ff[2];
	assign cell_b_pwm_n          = gate_lo_ff[2];
	assign switching_state       = sw_state_ff;
	assign bridge_output_voltage = level_ff;
	assign running               = running_ff;

endmodule // pspwm_gate_gen

// ---- gate_driver_model.sv ----
// Behavioural model of the isolated gate drivers and the bridge
`timescale 1ns/1ns
module gate_driver_model (
	// Gate pairs from the generator
	input  wire logic         pol, pol_n, ca, ca_n, cb, cb_n,
	// What the bridge makes of them
	output logic              shoot,
	output logic signed [2:0] level
);
	// pair overlap flag
	// A real driver would short the bus here, so the bench counts it
	assign shoot = (pol && pol_n) || (ca && ca_n) || (cb && cb_n);
	// bridge level
	// One gate per series pair, so three bits fix every switch
	assign level = 3'(ca) + 3'(cb) - (pol ? 3'h0 : 3'h2);
endmodule // gate_driver_model

// ---- pspwm_gate_properties.sv ----
// Port-level assertions for the gate generator
`timescale 1ns/1ns
module pspwm_gate_checker #(parameter int LINE_HALF = 20000) (
	// Clock, reset and controls
	input wire logic              mclk, arst_n, gate_enable, running,
	input wire logic [7:0]        dead_time,
	// Gate pairs and status
	input wire logic              polarity_select, polarity_select_n,
	input wire logic              cell_a_pwm, cell_a_pwm_n, cell_b_pwm, cell_b_pwm_n,
	input wire logic [3:0]        switching_state,
	input wire logic signed [2:0] bridge_output_voltage
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!arst_n);
	logic [19:0] pol_ff, nxt_pol, stop_ff, nxt_stop;
	// Long spans counted here, too long for repetition
	always_comb begin
		nxt_pol  = (polarity_select && running) ? pol_ff + 20'h00001 : 20'h00000;
		nxt_stop = (running && !gate_enable) ? stop_ff + 20'h00001 : 20'h00000;
	end
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			pol_ff  <= 20'h00000;
			stop_ff <= 20'h00000;
		end else begin
			pol_ff  <= nxt_pol;
			stop_ff <= nxt_stop;
		end
	end
	// State number to level; codes above 8 give an impossible level
	function automatic logic signed [2:0] lvl(input logic [3:0] s);
		case (s)
			4'h1: lvl = 3'sh2;
			4'h2, 4'h3: lvl = 3'sh1;
			4'h0, 4'h4, 4'h5: lvl = 3'sh0;
			4'h6, 4'h7: lvl = -3'sh1;
			4'h8: lvl = -3'sh2;
			default: lvl = 3'sh3;
		endcase
	endfunction
	sequence s_arm; $rose(gate_enable) && !running; endsequence
	sequence s_gap_a; !cell_a_pwm_n [*4]; endsequence
	sequence s_gap_b; !cell_b_pwm_n [*4]; endsequence
	property p_pol_pair; !(polarity_select && polarity_select_n); endproperty
	property p_a_pair; !(cell_a_pwm && cell_a_pwm_n); endproperty
	property p_b_pair; !(cell_b_pwm && cell_b_pwm_n); endproperty
	property p_level; bridge_output_voltage == lvl(switching_state); endproperty
	property p_start; s_arm |-> ##[2:4] running; endproperty
	property p_stop; stop_ff <= 20'h01392; endproperty
	property p_pol_len; pol_ff <= LINE_HALF; endproperty
	property p_gap_a; $fell(cell_a_pwm) && dead_time == 8'h03 |-> s_gap_a; endproperty
	property p_gap_b; $fell(cell_b_pwm) && dead_time == 8'h03 |-> s_gap_b; endproperty
	a_pol_pair: assert property (p_pol_pair) else $error("polarity pair overlap");
	a_a_pair: assert property (p_a_pair) else $error("cell A pair overlap");
	a_b_pair: assert property (p_b_pair) else $error("cell B pair overlap");
	a_level: assert property (p_level) else $error("level does not match state");
	a_start: assert property (p_start) else $error("run did not start");
	a_stop: assert property (p_stop) else $error("stop later than one period");
	a_pol_len: assert property (p_pol_len) else $error("polarity half too long");
	a_gap_a: assert property (p_gap_a) else $error("cell A dead gap short");
	a_gap_b: assert property (p_gap_b) else $error("cell B dead gap short");
endmodule // pspwm_gate_checker

bind pspwm_gate_gen pspwm_gate_checker #(.LINE_HALF(LINE_HALF)) chk_u (
	.mclk(mclk), .arst_n(arst_n), .gate_enable(gate_enable), .running(running),
	.dead_time(dead_time), .polarity_select(polarity_select),
	.polarity_select_n(polarity_select_n), .cell_a_pwm(cell_a_pwm),
	.cell_a_pwm_n(cell_a_pwm_n), .cell_b_pwm(cell_b_pwm), .cell_b_pwm_n(cell_b_pwm_n),
	.switching_state(switching_state), .bridge_output_voltage(bridge_output_voltage)
);

// ---- five_level_pspwm_gate_generator_test.sv ----
// Self-checking bench for the five-level gate generator
`timescale 1ns/1ns
`define CHK(nm, e, g) begin exp_q.push_back(16'(e)); nm_q.push_back(nm); got_v = 16'(g); ->got_ev; #1; end
module five_level_pspwm_gate_generator_test;
	localparam int LH = 30000;
	logic              mclk = 1'b0, arst_n = 1'b0, gate_enable = 1'b0;
	logic [11:0]       modulation_value = 12'h000;
	logic [7:0]        dead_time = 8'h03;
	logic              pol, pol_n, ca, ca_n, cb, cb_n, running, shoot;
	logic [3:0]        sst;
	logic signed [2:0] lvl, mlvl;
	logic [15:0]       got_v, exp_q[$];
	string             nm_q[$];
	event              got_ev;
	int n_errors = 0, cmp_count = 0, seed = 32'h0323, cyc = 0;
	int hist[16], ha, hb, ov, sh, nl, k, c, t0, nk, dl;

	pspwm_gate_gen #(.LINE_HALF(LH)) dut_u (
		.mclk(mclk), .arst_n(arst_n), .gate_enable(gate_enable),
		.modulation_value(modulation_value), .dead_time(dead_time),
		.polarity_select(pol), .polarity_select_n(pol_n), .cell_a_pwm(ca),
		.cell_a_pwm_n(ca_n), .cell_b_pwm(cb), .cell_b_pwm_n(cb_n),
		.switching_state(sst), .bridge_output_voltage(lvl), .running(running)
	);
	gate_driver_model drv_u (
		.pol(pol), .pol_n(pol_n), .ca(ca), .ca_n(ca_n), .cb(cb), .cb_n(cb_n),
		.shoot(shoot), .level(mlvl)
	);

	// Clock and a free cycle count
	always #5 mclk = ~mclk;
	always @(posedge mclk) cyc++;

	// Oldest note against each result as it shows up
	always @(got_ev) begin
		cmp_count++;
		if (exp_q[0] !== got_v) begin
			n_errors++;
			$display("BAD %s exp %h got %h", nm_q[0], exp_q[0], got_v);
		end
		void'(exp_q.pop_front());
		void'(nm_q.pop_front());
	end

	task tally_and_finish;
		if (n_errors == 0 && cmp_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// Histogram of states and gate activity over n cycles
	task automatic win(input int n, input logic signed [2:0] want);
		hist = '{default: 0};
		ha = 0;
		hb = 0;
		ov = 0;
		sh = 0;
		nl = 0;
		dl = 0;
		repeat (n) begin
			@(negedge mclk);
			hist[sst]++;
			ha += ca;
			hb += cb;
			ov += ca && cb;
			sh += shoot;
			nl += (mlvl == want);
			dl += (lvl == want);
			// Counted over every window of the run, so no unknown hides in the int tallies
			nk += $isunknown({pol, pol_n, ca, ca_n, cb, cb_n, sst, lvl, running});
		end
	endtask

	// Bounded wait; 0 running, 1 polarity complement, 2 polarity
	task automatic wait_for(input int sel, input logic v, input int lim);
		c = 0;
		while (((sel == 0) ? running : (sel == 1) ? pol_n : pol) !== v) begin
			@(negedge mclk);
			c++;
			if (c > lim) begin
				n_errors++;
				tally_and_finish();
			end
		end
	endtask

	// Main sequence: positive half, negative half, stop
	initial begin
		repeat (3) @(negedge mclk);
		arst_n = 1'b1;
		`CHK("reset", 0, {pol, pol_n, ca, ca_n, cb, cb_n, sst, lvl, running})
		k = 300 + ($unsigned($random(seed)) % 400);
		@(negedge mclk);
		modulation_value = 12'(k);
		gate_enable = 1'b1;
		wait_for(0, 1'b1, 20);
		`CHK("start", 3, c)
		repeat (6) @(negedge mclk);
		`CHK("pol", 2'b10, {pol, pol_n})
		win(5000, 3'sh1);
		modulation_value = 12'h7D0;
		`CHK("overlap", 0, ov)
		`CHK("duty_a", 1, ha >= 2 * k - 16 && ha <= 2 * k)
		`CHK("duty_b", 1, hb >= 2 * k - 16 && hb <= 2 * k)
		`CHK("pair", 1, hist[2] > 0 && hist[3] > 0 && hist[4] > 0 && hist[1] == 0)
		`CHK("half", ha + hb, nl)
		`CHK("shoot", 0, sh)
		win(5000, 3'sh2);
		// Zero dead time: each pulse loses one cycle at its rising edge
		dead_time = 8'h00;
		win(5000, 3'sh2);
		modulation_value = 12'h9C4;
		`CHK("full", 1, hist[1] > 0 && hist[4] == 0 && nl == ov && ov > 0)
		`CHK("dead0_a", 2 * 2000 - 2, ha)
		`CHK("dead0_b", 2 * 2000 - 2, hb)
		wait_for(1, 1'b1, LH);
		t0 = cyc;
		win(5000, -3'sh2);
		modulation_value = 12'(k);
		`CHK("neg_full", 1, hist[8] >= 4900 && nl >= 4900 && dl >= 4900)
		win(5000, -3'sh1);
		win(5000, -3'sh1);
		`CHK("neg_half", 1, hist[5] > 0 && hist[6] > 0 && hist[7] > 0 && nl > 0)
		`CHK("shoot_neg", 0, sh)
		wait_for(2, 1'b1, LH);
		`CHK("line", LH, cyc - t0)
		@(negedge mclk);
		gate_enable = 1'b0;
		wait_for(0, 1'b0, 5100);
		repeat (8) @(negedge mclk);
		`CHK("stop", 0, {pol, pol_n, ca, ca_n, cb, cb_n, sst, lvl})
		`CHK("known", 0, nk)
		tally_and_finish();
	end
endmodule // five_level_pspwm_gate_generator_test
